// ### pcu_pkg.sv
// Shared constants and types of the program counter unit
package pcu_pkg;
  // ----------------------------------------------------------------
  // Counter geometry and vectors
  // ----------------------------------------------------------------
  localparam int          PC_W          = 21;
  localparam int          TOP_W         = 5;
  localparam int          SP_W          = 5;
  localparam int          STACK_DEPTH   = 31;
  localparam int          WORD_W        = 16;
  localparam logic [20:0] RESET_VEC     = 21'h000000;
  localparam logic [20:0] HI_VEC        = 21'h000008;
  localparam logic [20:0] LO_VEC        = 21'h000018;
  localparam logic [20:0] PC_STEP       = 21'h000002;
  localparam logic [4:0]  SP_RESET      = 5'h00;
  localparam logic [4:0]  SP_TOP        = 5'h1F;
  localparam int          MEM_BYTES_DEF = 65536;
  localparam int          CFG_SPAN      = 8;
  localparam logic [1:0]  CFG_LAST      = 2'h3;
  localparam logic [1:0]  CFG_USED      = 2'h3;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_LOW       = 8'h00;
  localparam logic [7:0]  OFS_LATH      = 8'h04;
  localparam logic [7:0]  OFS_LATU      = 8'h08;
  localparam logic [7:0]  OFS_SP        = 8'h0C;
  localparam logic [7:0]  OFS_TOS       = 8'h10;
  localparam logic [7:0]  OFS_CFG1      = 8'h14;
  localparam logic [7:0]  OFS_CFG2      = 8'h18;
  localparam logic [7:0]  OFS_CFG3      = 8'h1C;
  localparam logic [7:0]  OFS_STAT      = 8'h20;
  // ----------------------------------------------------------------
  // Setup loader states, Gray along the load path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LD_IDLE  = 3'b000,
    LD_ADDR  = 3'b001,
    LD_WAIT  = 3'b011,
    LD_HOLD  = 3'b010,
    LD_STORE = 3'b110
  } pcu_ld_state_t;
endpackage

// ### pcu_links_if.sv
// Interfaces between the counter core, the setup loader and fetch gate
`timescale 1ns/1ns
interface pcu_cfg_if;
  logic        busy;     // Loader still copying
  logic [20:0] rd_addr;  // Setup word byte address
  logic [15:0] rd_data;  // Gated memory word
  logic [47:0] words;    // Three used setup words
  modport loader (output busy, rd_addr, words, input rd_data);
  modport core   (input busy, rd_addr, words, output rd_data);
endinterface

interface pcu_mem_if;
  logic [20:0] addr;     // Address the raw word belongs to
  logic [15:0] raw;      // Word from program memory
  logic [15:0] data;     // Word after range check
  modport gate (input addr, raw, output data);
  modport core (output addr, raw, input data);
endinterface

// ### pcu_fetch_gate.sv
// Returns zeros for fetches above the implemented memory
`timescale 1ns/1ns
module pcu_fetch_gate #(
  parameter int MEM_BYTES = pcu_pkg::MEM_BYTES_DEF  // Implemented bytes
) (
  input wire logic sys_clk,  // Core clock
  input wire logic rst_n,    // Async reset, low
  pcu_mem_if.gate  mem       // Address and words
);
  import pcu_pkg::*;
  localparam logic [21:0] LIMIT = 22'(MEM_BYTES);

  // ----------------------------------------------------------------
  // Range check
  // ----------------------------------------------------------------
  // Zero word executes as no-operation, so no fault path is needed
  wire in_range = {1'b0, mem.addr} < LIMIT;
  assign mem.data = in_range ? mem.raw : 16'h0000;  // R2

  a_beyond_zero: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_n)
    ({1'b0, mem.addr} >= LIMIT) |-> (mem.data == 16'h0000))
    else $error("fetch above memory not zero");
endmodule

// ### pcu_cfg_loader.sv
// Copies the setup words from the top of program memory after reset
`timescale 1ns/1ns
module pcu_cfg_loader #(
  parameter int MEM_BYTES = pcu_pkg::MEM_BYTES_DEF  // Implemented bytes
) (
  input wire logic  sys_clk,  // Core clock
  input wire logic  rst_n,    // Async reset, low
  pcu_cfg_if.loader cfg       // Read port and words
);
  import pcu_pkg::*;
  localparam logic [20:0] CFG_BASE = 21'(MEM_BYTES - CFG_SPAN);  // R7

  pcu_ld_state_t state;
  logic [1:0]    idx;
  logic [47:0]   words;
  logic          busy;
  logic [20:0]   rd_addr;

  assign cfg.busy    = busy;
  assign cfg.rd_addr = rd_addr;
  assign cfg.words   = words;

  // ----------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------
  // Every reset restarts at the lowest setup word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= LD_ADDR;  // R5
      idx     <= 2'h0;
      busy    <= 1'b1;
      words   <= 48'h000000000000;
      rd_addr <= 21'h000000;
    end else begin
      case (state)
        LD_ADDR: begin
          rd_addr <= CFG_BASE + {18'h00000, idx, 1'b0};  // R6 R7
          state   <= LD_WAIT;
        end
        LD_WAIT:  state <= LD_HOLD;
        LD_HOLD:  state <= LD_STORE;
        LD_STORE: begin
          // Fourth word is reserved and dropped
          if (idx < CFG_USED) begin
            words[idx*16 +: 16] <= cfg.rd_data;  // R5 R6
          end
          if (idx == CFG_LAST) begin
            state <= LD_IDLE;
            busy  <= 1'b0;
          end else begin
            idx   <= idx + 2'h1;
            state <= LD_ADDR;
          end
        end
        LD_IDLE:  state <= LD_IDLE;
        default:  state <= LD_IDLE;
      endcase
    end
  end

  a_cfg_addr: assert property ( // R7
    @(posedge sys_clk) disable iff (!rst_n)
    (state == LD_HOLD) |-> (rd_addr == CFG_BASE + {18'h00000, idx, 1'b0}))
    else $error("setup word address wrong");

  a_cfg_done: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> busy ##[14:20] !busy)
    else $error("setup copy did not finish");
endmodule

// ### pcu_top.sv
// Program counter, holding latches, return push and setup copy
//
// Functional notes
// R1: Counter is 21 bits, 2 MB range
// R2: Fetch above implemented memory returns zeros
// R3: Every reset loads counter with 0000h
// R4: High interrupt 0008h, low interrupt 0018h
// R5: Top four words copied to setup on reset
// R6: Setup bytes ascending; fourth word reserved
// R7: Setup area FFF8h or 1FFF8h by size
// R8: Three counter bytes; only low byte accessible
// R9: Middle byte updated only via high latch
// R10: Top byte updated only via upper latch
// R11: Low byte write also loads counter from both latches
// R12: Low byte read copies upper bytes to latches
// R13: Counter bit zero always zero
// R14: Sequential step adds two
// R15: Calls, gotos, branches load target directly
// R16: Enabled interrupt wake loads matching vector
// R17: Wake pushes counter, pointer advances
// R18: Pointer increments before push; 5 bits, 31 entries
`timescale 1ns/1ns
module pcu_top #(
  parameter int MEM_BYTES = pcu_pkg::MEM_BYTES_DEF  // 65536 or 131072
) (
  input  wire logic                     sys_clk,      // Core clock
  input  wire logic                     rst_n,        // Async reset, low
  input  wire logic [pcu_pkg::ADDR_W-1:0] paddr,      // APB address
  input  wire logic                     psel,         // APB select
  input  wire logic                     penable,      // APB enable
  input  wire logic                     pwrite,       // APB direction
  input  wire logic [31:0]              pwdata,       // APB write data
  output logic      [31:0]              prdata,       // APB read data
  output logic                          pready,       // APB ready
  output logic                          pslverr,      // APB error
  input  wire logic                     step,         // Advance one word
  input  wire logic                     jump_valid,   // Direct load
  input  wire logic [pcu_pkg::PC_W-1:0] jump_target,  // Branch target
  input  wire logic                     irq_wake,     // Interrupt wake
  input  wire logic                     irq_high,     // Wake is high prio
  input  wire logic                     high_priority_global_enable, // GIE high
  input  wire logic                     low_priority_global_enable,  // GIE low
  output logic      [pcu_pkg::PC_W-1:0] prog_addr,    // Memory address
  input  wire logic [15:0]              prog_rdata,   // Memory word
  output logic      [15:0]              instr_word,   // Fetched word
  output logic      [pcu_pkg::PC_W-1:0] instr_addr,   // Its address
  output logic      [pcu_pkg::PC_W-1:0] pc_value,     // Counter
  output logic                          core_run,     // Setup loaded
  output logic      [15:0]              first_setup_word,  // Setup 1
  output logic      [15:0]              second_setup_word, // Setup 2
  output logic      [15:0]              third_setup_word   // Setup 3
);
  import pcu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]        counter_low_byte;
  logic [7:0]        counter_middle_byte;
  logic [TOP_W-1:0]  counter_top_byte;
  logic [7:0]        high_holding_latch;
  logic [7:0]        upper_holding_latch;
  logic [SP_W-1:0]   return_stack_pointer;
  logic [PC_W-1:0]   ret_stack [1:STACK_DEPTH];
  logic [PC_W-1:0]   prog_addr_d;
  logic [PC_W-1:0]   next_pc;
  logic [31:0]       rd_mux;

  pcu_cfg_if cfg_bus ();
  pcu_mem_if mem_bus ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  pcu_cfg_loader #(.MEM_BYTES(MEM_BYTES)) u_loader (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cfg     (cfg_bus.loader)
  );

  pcu_fetch_gate #(.MEM_BYTES(MEM_BYTES)) u_gate (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .mem     (mem_bus.gate)
  );

  // Word returned one cycle after the address, so check its own address
  assign mem_bus.addr    = prog_addr_d;
  assign mem_bus.raw     = prog_rdata;
  assign cfg_bus.rd_data = mem_bus.data;  // R2

  assign first_setup_word  = cfg_bus.words[15:0];
  assign second_setup_word = cfg_bus.words[31:16];
  assign third_setup_word  = cfg_bus.words[47:32];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable & pready;
  wire hit_low    = paddr == OFS_LOW;
  wire hit_lath   = paddr == OFS_LATH;
  wire hit_latu   = paddr == OFS_LATU;
  wire hit_sp     = paddr == OFS_SP;
  wire hit_tos    = paddr == OFS_TOS;
  wire hit_cfg1   = paddr == OFS_CFG1;
  wire hit_cfg2   = paddr == OFS_CFG2;
  wire hit_cfg3   = paddr == OFS_CFG3;
  wire hit_stat   = paddr == OFS_STAT;
  wire hit_any    = hit_low | hit_lath | hit_latu | hit_sp | hit_tos |
                    hit_cfg1 | hit_cfg2 | hit_cfg3 | hit_stat;
  wire wr_low     = apb_access & pwrite & hit_low;
  wire wr_lath    = apb_access & pwrite & hit_lath;
  wire wr_latu    = apb_access & pwrite & hit_latu;
  wire wr_sp      = apb_access & pwrite & hit_sp;
  wire rd_low     = apb_setup & ~pwrite & hit_low;

  // ----------------------------------------------------------------
  // Counter next value
  // ----------------------------------------------------------------
  wire [PC_W-1:0] pc = {counter_top_byte, counter_middle_byte,
                        counter_low_byte};  // R1 R8
  wire irq_take = core_run & irq_wake &
                  (high_priority_global_enable | low_priority_global_enable);
  wire [PC_W-1:0] irq_vec  = irq_high ? HI_VEC : LO_VEC;  // R4
  wire [PC_W-1:0] pc_step  = pc + PC_STEP;  // R14
  wire [PC_W-1:0] jump_pc  = {jump_target[PC_W-1:1], 1'b0};  // R15
  wire [PC_W-1:0] latch_pc = {upper_holding_latch[TOP_W-1:0],
                              high_holding_latch, pwdata[7:1], 1'b0};  // R11
  wire            can_push = return_stack_pointer != SP_TOP;
  wire [SP_W-1:0] sp_inc   = return_stack_pointer + 5'h01;  // R18
  wire [PC_W-1:0] tos_value =
    (return_stack_pointer == SP_RESET) ? 21'h000000 :
    ret_stack[return_stack_pointer];

  // Interrupt wins over a branch, which wins over a software write
  assign next_pc = !core_run  ? pc :
                   irq_take   ? irq_vec :   // R16
                   jump_valid ? jump_pc :   // R15
                   wr_low     ? latch_pc :  // R9 R10 R11
                   step       ? pc_step :   // R14
                   pc;

  // ----------------------------------------------------------------
  // Counter bytes
  // ----------------------------------------------------------------
  // Core is held at the reset vector until setup has been copied
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_low_byte    <= RESET_VEC[7:0];    // R3
      counter_middle_byte <= RESET_VEC[15:8];   // R3
      counter_top_byte    <= RESET_VEC[20:16];  // R3
    end else begin
      counter_low_byte    <= {next_pc[7:1], 1'b0};  // R13
      counter_middle_byte <= next_pc[15:8];         // R9
      counter_top_byte    <= next_pc[20:16];        // R10
    end
  end

  // ----------------------------------------------------------------
  // Holding latches
  // ----------------------------------------------------------------
  // Read of the low byte snapshots the upper bytes for computed jumps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_holding_latch  <= 8'h00;
      upper_holding_latch <= 8'h00;
    end else if (rd_low) begin
      high_holding_latch  <= counter_middle_byte;         // R12
      upper_holding_latch <= {3'h0, counter_top_byte};    // R12
    end else begin
      if (wr_lath) begin
        high_holding_latch <= pwdata[7:0];
      end
      if (wr_latu) begin
        upper_holding_latch <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack pointer and storage
  // ----------------------------------------------------------------
  // A full stack is not overwritten; the last entry stays intact
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      return_stack_pointer <= SP_RESET;
    end else if (irq_take && can_push) begin
      return_stack_pointer <= sp_inc;  // R17 R18
    end else if (wr_sp) begin
      return_stack_pointer <= pwdata[SP_W-1:0];
    end
  end

  // Storage is plain memory, no reset needed
  always_ff @(posedge sys_clk) begin
    if (irq_take && can_push) begin
      ret_stack[sp_inc] <= pc;  // R17 R18
    end
  end

  // ----------------------------------------------------------------
  // Fetch path
  // ----------------------------------------------------------------
  // Loader borrows the memory port until setup is in place
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr   <= 21'h000000;
      prog_addr_d <= 21'h000000;
      instr_word  <= 16'h0000;
      instr_addr  <= 21'h000000;
      core_run    <= 1'b0;
    end else begin
      prog_addr   <= cfg_bus.busy ? cfg_bus.rd_addr : next_pc;  // R5
      prog_addr_d <= prog_addr;
      instr_word  <= mem_bus.data;  // R2
      instr_addr  <= prog_addr_d;
      core_run    <= ~cfg_bus.busy;
    end
  end

  assign pc_value = pc;

  // ----------------------------------------------------------------
  // APB read data and answer
  // ----------------------------------------------------------------
  assign rd_mux =
    hit_low  ? {24'h000000, counter_low_byte} :
    hit_lath ? {24'h000000, high_holding_latch} :
    hit_latu ? {24'h000000, upper_holding_latch} :
    hit_sp   ? {27'h0000000, return_stack_pointer} :
    hit_tos  ? {11'h000, tos_value} :
    hit_cfg1 ? {16'h0000, first_setup_word} :
    hit_cfg2 ? {16'h0000, second_setup_word} :
    hit_cfg3 ? {16'h0000, third_setup_word} :
    hit_stat ? {31'h00000000, core_run} :
    32'h00000000;

  // One access cycle: ready rises the cycle after setup
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_push(logic [4:0] sp0, logic [20:0] pc0);
    (return_stack_pointer == sp0 + 5'h01) ##0 (tos_value == pc0);
  endsequence

  a_bit0_zero: assert property ( // R13
    @(posedge sys_clk) disable iff (!rst_n) counter_low_byte[0] == 1'b0)
    else $error("counter bit zero set");

  a_reset_vector: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_n) !core_run |-> pc == RESET_VEC)
    else $error("counter left reset vector before run");

  a_step_two: assert property ( // R14
    @(posedge sys_clk) disable iff (!rst_n)
    (core_run && step && !irq_take && !jump_valid && !wr_low)
    |=> pc == $past(pc_step))
    else $error("sequential step not two");

  a_irq_vector: assert property ( // R4 R16
    @(posedge sys_clk) disable iff (!rst_n)
    irq_take |=> pc == ($past(irq_high) ? 21'h000008 : 21'h000018))
    else $error("interrupt vector wrong");

  a_push_stack: assert property ( // R17 R18
    @(posedge sys_clk) disable iff (!rst_n)
    (irq_take && can_push) |=>
    s_push($past(return_stack_pointer), $past(pc)))
    else $error("interrupt push wrong");

  a_latch_xfer: assert property ( // R11
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_low && core_run && !irq_take && !jump_valid) |=>
    pc == {$past(upper_holding_latch[4:0]), $past(high_holding_latch),
           $past(pwdata[7:1]), 1'b0})
    else $error("latch transfer wrong");

  a_latch_copy: assert property ( // R12
    @(posedge sys_clk) disable iff (!rst_n)
    rd_low |=> (high_holding_latch == $past(counter_middle_byte)) &&
               (upper_holding_latch == {3'h0, $past(counter_top_byte)}))
    else $error("latch copy on read wrong");

  a_jump_direct: assert property ( // R15
    @(posedge sys_clk) disable iff (!rst_n)
    (jump_valid && core_run && !irq_take) |=> pc == $past(jump_pc))
    else $error("direct jump used latches");

  a_upper_hold: assert property ( // R9 R10
    @(posedge sys_clk) disable iff (!rst_n)
    (!core_run || (!irq_take && !jump_valid && !wr_low && !step))
    |=> $stable(pc[20:8]))
    else $error("upper bytes moved without cause");

  // Wake with both enables off, nothing else asking
  sequence s_masked_wake;
    core_run && irq_wake && !jump_valid && !wr_low && !step && !wr_sp &&
    !high_priority_global_enable && !low_priority_global_enable;
  endsequence

  a_wake_masked: assert property ( // R16 R17
    @(posedge sys_clk) disable iff (!rst_n)
    s_masked_wake |=> $stable(pc) && $stable(return_stack_pointer))
    else $error("masked wake moved counter or pointer");

  // Full stack keeps its pointer; the vector is still taken
  a_full_no_push: assert property ( // R18
    @(posedge sys_clk) disable iff (!rst_n)
    (irq_take && !can_push) |=> return_stack_pointer == SP_TOP)
    else $error("full stack pointer moved");

  // Word and address must leave the pipeline together
  a_fetch_gated: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_n)
    ({1'b0, instr_addr} >= 22'(MEM_BYTES)) |-> (instr_word == 16'h0000))
    else $error("word above memory not zero");

  a_fetch_pipe: assert property ( // R1
    @(posedge sys_clk) disable iff (!rst_n)
    core_run |-> (instr_addr == $past(prog_addr, 2)))
    else $error("fetch address pipeline slipped");

  a_run_vector: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(core_run) |-> (pc == RESET_VEC))
    else $error("run did not start at reset vector");

  a_unmapped_err: assert property ( // R8
    @(posedge sys_clk) disable iff (!rst_n)
    (apb_setup && !hit_any) |=> (pslverr && pready))
    else $error("unmapped access not refused");
endmodule

// ### tb.sv
// Self-checking testbench of the program counter unit
`timescale 1ns/1ns
module tb;
  import pcu_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  localparam int MEM = 65536;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        step, jump_valid, irq_wake, irq_high, core_run, err;
  logic        high_priority_global_enable, low_priority_global_enable;
  logic [20:0] jump_target, prog_addr, instr_addr, pc_value;
  logic [15:0] prog_rdata, instr_word, cfg1, cfg2, cfg3;
  int          fail_count;
  int          compares;

  pcu_top #(.MEM_BYTES(MEM)) pcu_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step(step), .jump_valid(jump_valid), .jump_target(jump_target),
    .irq_wake(irq_wake), .irq_high(irq_high),
    .high_priority_global_enable(high_priority_global_enable),
    .low_priority_global_enable(low_priority_global_enable), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .instr_word(instr_word), .instr_addr(instr_addr),
    .pc_value(pc_value), .core_run(core_run), .first_setup_word(cfg1),
    .second_setup_word(cfg2), .third_setup_word(cfg3));

  // Clock; memory word derived from its address so any slip shows
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] mem_word(input logic [20:0] a);
    return a[16:1] ^ 16'h5A5A;
  endfunction
  // One-cycle read latency, as the fetch port expects
  always @(posedge sys_clk) prog_rdata <= mem_word(prog_addr);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      conclude();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic jump(input logic [20:0] t);
    @(posedge sys_clk);
    jump_valid <= 1'b1; jump_target <= t;
    @(posedge sys_clk);
    jump_valid <= 1'b0;
    #1;
  endtask
  task automatic irq(input logic h, input logic eh, input logic el);
    @(posedge sys_clk);
    irq_wake <= 1'b1; irq_high <= h;
    high_priority_global_enable <= eh; low_priority_global_enable <= el;
    @(posedge sys_clk);
    irq_wake <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset, then wait for the setup copy from the top of memory
  task automatic t_reset();
    int n;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("pc in reset", pc_value, 0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge sys_clk);
      #1;
      if (core_run === 1'b1) break;
    end
    if (n == 60) begin
      fail_count++;
      conclude();
    end
    check("pc after reset", pc_value, 0);
    check("setup 1", cfg1, mem_word(21'h00FFF8));
    check("setup 2", cfg2, mem_word(21'h00FFFA));
    check("setup 3", cfg3, mem_word(21'h00FFFC));
    apb(OFS_CFG1, 1'b0, 0);
    check("setup 1 reg", rd, {16'h0, mem_word(21'h00FFF8)});
    apb(OFS_SP, 1'b0, 0);
    check("pointer reset", rd, 0);
    apb(OFS_STAT, 1'b0, 0);
    check("status run", rd, 1);
  endtask
  // Sequential stepping by two
  task automatic t_seq();
    jump(21'h000100);
    @(posedge sys_clk);
    step <= 1'b1;
    repeat (4) @(posedge sys_clk);
    step <= 1'b0;
    #1;
    check("pc stepped", pc_value, 21'h000108);
  endtask
  // Direct load ignores the latches; write of low byte uses them
  task automatic t_load();
    apb(OFS_LATH, 1'b1, 32'h000000EE);
    apb(OFS_LATU, 1'b1, 32'h00000015);
    jump(21'h1ABCD1);
    check("pc jump", pc_value, 21'h1ABCD0);
    apb(OFS_LOW, 1'b1, 32'h00000037);
    #1;
    check("pc low write", pc_value, 21'h15EE36);
  endtask
  // Low byte read copies the upper bytes to the latches
  task automatic t_low_read();
    jump(21'h0A5C20);
    apb(OFS_LOW, 1'b0, 0);
    check("low byte read", rd, 32'h20);
    apb(OFS_LATH, 1'b0, 0);
    check("high latch", rd, 32'h5C);
    apb(OFS_LATU, 1'b0, 0);
    check("upper latch", rd, 32'h0A);
  endtask
  // Wake vectoring, push and the full stack boundary
  task automatic t_irq();
    irq(1'b1, 1'b1, 1'b0);
    check("high vector", pc_value, 21'h000008);
    apb(OFS_SP, 1'b0, 0);
    check("pointer one", rd, 1);
    apb(OFS_TOS, 1'b0, 0);
    check("top pushed", rd, 32'h0A5C20);
    irq(1'b0, 1'b0, 1'b1);
    check("low vector", pc_value, 21'h000018);
    apb(OFS_TOS, 1'b0, 0);
    check("top second", rd, 32'h8);
    irq(1'b1, 1'b0, 1'b0);
    check("no vector", pc_value, 21'h000018);
    apb(OFS_SP, 1'b0, 0);
    check("pointer two", rd, 2);
    apb(OFS_SP, 1'b1, 32'h1F);
    irq(1'b1, 1'b1, 1'b1);
    check("full vector", pc_value, 21'h000008);
    apb(OFS_SP, 1'b0, 0);
    check("pointer full", rd, 31);
  endtask
  // Fetch across the end of implemented memory returns zeros
  task automatic t_fetch();
    jump(21'h00FFF0);
    @(posedge sys_clk);
    step <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      #1;
      check("fetch word", instr_word, (instr_addr >= MEM) ? 0 : mem_word(instr_addr));
      check("fetch addr", instr_addr, 21'h00FFF0 + 2 * ((i > 0) ? i - 1 : 0));
    end
    @(posedge sys_clk);
    step <= 1'b0;
  endtask
  // Unmapped addresses are refused without effect
  task automatic t_unmapped();
    apb(8'h24, 1'b0, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
    jump(21'h000040);
    apb(8'h28, 1'b1, 32'hFF);
    check("unmapped werr", err, 1);
    check("pc kept", pc_value, 21'h000040);
  endtask

  // ----------------------------------------------------------------
  // Main sequence; a second reset is taken after the last scenario
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0; compares = 0; rst_n = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    step = 1'b0; jump_valid = 1'b0; jump_target = 21'h0; irq_wake = 1'b0;
    irq_high = 1'b0; high_priority_global_enable = 1'b0;
    low_priority_global_enable = 1'b0;
    t_reset();
    t_seq();
    t_load();
    t_low_read();
    t_irq();
    t_fetch();
    t_unmapped();
    t_reset();
    conclude();
  end
endmodule
